// *** async_serial_tx_rx_core.sv ***
`timescale 1ns/10ps
`include "serial_core_defines.svh"
module async_serial_tx_rx_core (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // baud rate setup
  input wire logic [1:0] die_link_prescale,
  input wire logic [12:0] baud_divisor,
  // common frame format
  input wire logic nine_bit_mode,
  // transmitter controls
  input wire logic transmitter_on,
  input wire logic tx_polarity_invert,
  input wire logic long_break_select,
  input wire logic queue_break_ctl,
  // transmit buffer write
  input wire serial_core_pkg::char_t tx_data,
  input wire logic tx_write,
  // transmitter status
  output logic tx_buffer_empty_flag,
  output logic tx_done_flag,
  // transmit pin
  output logic txd,
  output logic txd_oe,
  // receiver controls
  input wire logic receiver_on,
  input wire logic rx_polarity_invert,
  // receive pin
  input wire logic rxd,
  // receive buffer access
  input wire logic status_read,
  input wire logic data_read,
  output serial_core_pkg::char_t rx_data,
  output logic rx_buffer_full_flag,
  output logic noise_flag,
  output logic framing_error_flag,
  output logic overrun_flag
);
  import serial_core_pkg::*;

  // bit count of an idle, data or break character
  function automatic logic [3:0] char_bits(input logic nine, input logic brk,
                                           input logic lng);
    logic [3:0] n;
    n = nine ? `FRAME_BITS_9 : `FRAME_BITS_8;
    if (brk && lng) n = n + `LONG_BREAK_EXTRA;
    return n;
  endfunction

  logic [2:0] pre_cnt;
  logic [12:0] baud_cnt;
  tx_state_e tx_state;
  logic [13:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_phase;
  char_t tx_buf;
  logic idle_pending;
  logic brk_pending;
  logic te_prev;
  logic sbk_prev;
  logic clr_armed;
  rx_link_if lk ();

  // baud timing: die clock through prescale, then the modulo divider
  wire [2:0] pre_mask = 3'h7 >> (2'h3 - die_link_prescale);
  wire pre_tick = (pre_cnt & pre_mask) == pre_mask;
  wire div_on = baud_divisor != 13'h0000;
  wire baud_wrap = baud_cnt >= (baud_divisor - 13'h0001);
  wire tick16 = pre_tick && div_on && baud_wrap;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_cnt <= 3'h0;
      baud_cnt <= 13'h0000;
    end else if (ce) begin
      pre_cnt <= pre_cnt + 3'h1;
      // a divisor lowered below the count wraps at once, no long stall
      if (pre_tick) baud_cnt <= (baud_wrap || !div_on) ? 13'h0000 : baud_cnt + 13'h0001;
    end
  end

  // transmitter decoding
  wire active = tx_state == TX_ACTIVE;
  wire bit_tick = tick16 && (tx_phase == `PHASE_LAST);
  wire shifter_free = tx_left <= 4'h1;
  wire te_rise = transmitter_on && !te_prev;
  wire sbk_rise = queue_break_ctl && !sbk_prev;
  wire slot = active && bit_tick && shifter_free;
  wire load_idle = slot && idle_pending;
  wire load_break = slot && !idle_pending && brk_pending;
  wire load_data = slot && !idle_pending && !brk_pending && !tx_buffer_empty_flag
    && transmitter_on;
  wire go_quiet = slot && !load_idle && !load_break && !load_data;
  wire write_ok = tx_write && tx_buffer_empty_flag;
  wire [13:0] data_frame = nine_bit_mode ? {3'h7, 1'b1, tx_buf, 1'b0}
    : {4'hF, 1'b1, tx_buf[7:0], 1'b0};

  // queued idle and break characters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      te_prev <= 1'b0;
      sbk_prev <= 1'b0;
      idle_pending <= 1'b0;
      brk_pending <= 1'b0;
    end else if (ce) begin
      te_prev <= transmitter_on;
      sbk_prev <= queue_break_ctl;
      if (te_rise) idle_pending <= 1'b1;
      else if (load_idle) idle_pending <= 1'b0;
      if (sbk_rise || (load_break && queue_break_ctl)) brk_pending <= 1'b1;
      else if (load_break) brk_pending <= 1'b0;
    end
  end

  // the pin is kept until the shifter and any queued idle or break have gone out
  always_ff @(posedge clk) begin
    if (sys_rst) tx_state <= TX_OFF;
    else if (ce) begin
      unique case (tx_state)
        TX_OFF: if (te_rise) tx_state <= TX_ACTIVE;
        TX_ACTIVE: if (go_quiet && !transmitter_on) tx_state <= TX_OFF;
      endcase
    end
  end

  // transmit shifter, loads only on a bit boundary of the baud clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_phase <= 4'h0;
      tx_shift <= `SHIFT_IDLE;
      tx_left <= 4'h0;
    end else if (ce) begin
      if (tick16) tx_phase <= tx_phase + 4'h1;
      if (load_idle) begin
        tx_shift <= `SHIFT_IDLE;
        tx_left <= char_bits(nine_bit_mode, 1'b0, long_break_select);
      end else if (load_break) begin
        tx_shift <= `SHIFT_BREAK;
        tx_left <= char_bits(nine_bit_mode, 1'b1, long_break_select);
      end else if (load_data) begin
        tx_shift <= data_frame;
        tx_left <= char_bits(nine_bit_mode, 1'b0, long_break_select);
      end else if (go_quiet) begin
        tx_shift <= `SHIFT_IDLE;
        tx_left <= 4'h0;
      end else if (active && bit_tick && !shifter_free) begin
        tx_shift <= {1'b1, tx_shift[13:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // transmit buffer and its flags; a set beats a write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_buf <= 9'h000;
      tx_buffer_empty_flag <= 1'b1;
      tx_done_flag <= 1'b1;
    end else if (ce) begin
      if (write_ok) tx_buf <= tx_data;
      if (load_data) tx_buffer_empty_flag <= 1'b1;
      else if (write_ok) tx_buffer_empty_flag <= 1'b0;
      if (go_quiet) tx_done_flag <= 1'b1;
      else if (load_idle || load_break || load_data || write_ok) tx_done_flag <= 1'b0;
    end
  end

  // pin drivers straight from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txd <= 1'b1;
      txd_oe <= 1'b0;
    end else if (ce) begin
      txd <= tx_shift[0] ^ tx_polarity_invert;
      txd_oe <= active;
    end
  end

  // receiver sampler
  assign lk.tick16 = tick16;
  assign lk.nine_bit = nine_bit_mode;
  assign lk.rx_invert = rx_polarity_invert;
  assign lk.enable = receiver_on;

  serial_rx_sampler u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .rxd_pin(rxd),
    .lk(lk.rxer)
  );

  // receive buffer decoding
  wire rx_load = lk.done && !framing_error_flag && !rx_buffer_full_flag;
  wire rx_lost = lk.done && !framing_error_flag && rx_buffer_full_flag;
  wire rx_clear = data_read && clr_armed;

  // two-step clear: status read while full or framing error stands, then a data read
  always_ff @(posedge clk) begin
    if (sys_rst) clr_armed <= 1'b0;
    else if (ce) begin
      if (status_read && (rx_buffer_full_flag || framing_error_flag)) clr_armed <= 1'b1;
      else if (data_read) clr_armed <= 1'b0;
    end
  end

  // receive buffer; a new character wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data <= 9'h000;
      rx_buffer_full_flag <= 1'b0;
      noise_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else if (ce) begin
      if (rx_load) begin
        rx_data <= lk.data;
        rx_buffer_full_flag <= 1'b1;
        noise_flag <= lk.noise;
        framing_error_flag <= lk.framing;
      end else if (rx_clear) begin
        rx_buffer_full_flag <= 1'b0;
        noise_flag <= 1'b0;
        framing_error_flag <= 1'b0;
      end
      if (rx_lost) overrun_flag <= 1'b1;
      else if (rx_clear) overrun_flag <= 1'b0;
    end
  end

  property p_polarity;
    @(posedge clk) disable iff (sys_rst)
    ce |=> txd == ($past(tx_shift[0]) ^ $past(tx_polarity_invert));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("transmit line polarity wrong");

  property p_data_load;
    @(posedge clk) disable iff (sys_rst)
    (ce && load_data) |=> tx_buffer_empty_flag && !tx_done_flag && !tx_shift[0]
      && tx_left == ($past(nine_bit_mode) ? 4'hB : 4'hA);
  endproperty
  a_data_load: assert property (p_data_load)
    else $error("data load did not set buffer empty or frame length");

  property p_break_len;
    @(posedge clk) disable iff (sys_rst)
    (ce && load_break) |=> tx_shift == 14'h0000
      && tx_left == ($past(long_break_select) ? ($past(nine_bit_mode) ? 4'hE : 4'hD)
                     : ($past(nine_bit_mode) ? 4'hB : 4'hA));
  endproperty
  a_break_len: assert property (p_break_len)
    else $error("break character length wrong");

  property p_break_requeue;
    @(posedge clk) disable iff (sys_rst)
    (ce && load_break && queue_break_ctl) |=> brk_pending;
  endproperty
  a_break_requeue: assert property (p_break_requeue)
    else $error("held break control did not requeue a break");

  property p_done_set;
    @(posedge clk) disable iff (sys_rst)
    (ce && active && bit_tick && tx_left == 4'h1 && !idle_pending && !brk_pending
      && (tx_buffer_empty_flag || !transmitter_on)) |=> tx_done_flag && tx_shift[0];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("transmit done not set after last stop bit");

  property p_hold_pin;
    @(posedge clk) disable iff (sys_rst)
    (ce && active && (tx_left > 4'h1 || idle_pending)) |=> ##1 txd_oe;
  endproperty
  a_hold_pin: assert property (p_hold_pin)
    else $error("pin released with work still queued");

  property p_rx_load;
    @(posedge clk) disable iff (sys_rst)
    (ce && lk.done && !rx_buffer_full_flag && !framing_error_flag)
      |=> rx_buffer_full_flag && rx_data == $past(lk.data);
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("completed character not moved to buffer");

  property p_overrun;
    @(posedge clk) disable iff (sys_rst)
    (ce && lk.done && rx_buffer_full_flag && !framing_error_flag)
      |=> overrun_flag && $stable(rx_data);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or buffer overwritten");

  property p_fe_block;
    @(posedge clk) disable iff (sys_rst)
    (ce && lk.done && framing_error_flag) |=> $stable(rx_data);
  endproperty
  a_fe_block: assert property (p_fe_block)
    else $error("character transferred while framing error stands");

  property p_clear_seq;
    @(posedge clk) disable iff (sys_rst)
    (ce && data_read && !clr_armed && !lk.done)
      |=> rx_buffer_full_flag == $past(rx_buffer_full_flag);
  endproperty
  a_clear_seq: assert property (p_clear_seq)
    else $error("buffer full cleared without status read first");
endmodule

// *** async_serial_tx_rx_core_tb.sv ***
`timescale 1ns/10ps
module async_serial_tx_rx_core_tb;
  import serial_core_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] die_link_prescale = 2'h0;
  logic [12:0] baud_divisor = 13'h0001;
  logic nine_bit_mode = 1'b0;
  logic transmitter_on = 1'b0;
  logic tx_polarity_invert = 1'b0;
  logic long_break_select = 1'b0;
  logic queue_break_ctl = 1'b0;
  char_t tx_data = 9'h000;
  logic tx_write = 1'b0;
  logic receiver_on = 1'b0;
  logic rx_polarity_invert = 1'b0;
  logic status_read = 1'b0;
  logic data_read = 1'b0;
  logic [7:0] bit_clks = 8'h10;
  logic tx_buffer_empty_flag, tx_done_flag, txd, txd_oe, rxd, tx_line;
  logic rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag;
  char_t rx_data;
  logic [15:0] got_word;
  logic [7:0] got_cnt;
  logic full_q = 1'b0;
  logic [15:0] exp_tx[$];
  logic [10:0] exp_rx[$];
  int errors = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  // released pin: the port logic drives the idle level, so no false start appears
  assign tx_line = txd_oe ? txd : ~tx_polarity_invert;

  async_serial_tx_rx_core u_dut (.clk, .sys_rst, .ce, .die_link_prescale, .baud_divisor,
    .nine_bit_mode, .transmitter_on, .tx_polarity_invert, .long_break_select,
    .queue_break_ctl, .tx_data, .tx_write, .tx_buffer_empty_flag, .tx_done_flag, .txd,
    .txd_oe, .receiver_on, .rx_polarity_invert, .rxd, .status_read, .data_read, .rx_data,
    .rx_buffer_full_flag, .noise_flag, .framing_error_flag, .overrun_flag);

  serial_peer u_peer (.clk, .nine(nine_bit_mode), .inv(tx_polarity_invert), .bit_clks,
    .line(tx_line), .rxd, .got_word, .got_cnt);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      errors++;
    end
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout;
    $display("ERROR t=%0t wait limit reached", $time);
    errors++;
    summarize();
  endtask

  // wait until every noted result has arrived and the transmitter is done
  task automatic drain(input int bound);
    int k;
    k = 0;
    while (!(exp_tx.size() == 0 && exp_rx.size() == 0 && tx_done_flag === 1'b1)) begin
      @(negedge clk);
      k++;
      if (k > bound) timeout();
    end
  endtask

  // one buffer write once the buffer is free; the flag must drop after it
  task automatic put(input char_t d);
    int k;
    k = 0;
    while (tx_buffer_empty_flag !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 3000) timeout();
    end
    exp_tx.push_back({7'h00, nine_bit_mode ? d : {1'b0, d[7:0]}});
    tx_data = d;
    tx_write = 1'b1;
    @(negedge clk);
    tx_write = 1'b0;
    @(negedge clk);
    check({15'h0000, tx_buffer_empty_flag}, 16'h0000);
  endtask

  // status read then data read
  task automatic clear_rx;
    status_read = 1'b1;
    @(negedge clk);
    status_read = 1'b0;
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    repeat (2) @(negedge clk);
    check({12'h000, rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag},
          16'h0000);
  endtask

  // transmit results, compared as the far end decodes them
  always @(got_cnt) begin
    if (got_cnt !== 8'h00) begin
      if (exp_tx.size() == 0) check(got_word, 16'hFFFF);
      else check(got_word, exp_tx.pop_front());
    end
  end

  // receive results, compared when the buffer turns full
  always @(posedge clk) begin
    if (rx_buffer_full_flag === 1'b1 && full_q !== 1'b1) begin
      if (exp_rx.size() == 0)
        check({5'h00, noise_flag, framing_error_flag, rx_data}, 16'hFFFF);
      else
        check({5'h00, noise_flag, framing_error_flag, rx_data},
              {5'h00, exp_rx.pop_front()});
    end
    full_q <= rx_buffer_full_flag;
  end

  // hang guard
  initial begin
    repeat (100000) @(negedge clk);
    timeout();
  end

  initial begin : main
    char_t d;
    void'($urandom(64586));
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check({8'h00, txd, txd_oe, tx_buffer_empty_flag, tx_done_flag, rx_buffer_full_flag,
           noise_flag, framing_error_flag, overrun_flag}, 16'h00B0);
    // every format and polarity, three writes back to back
    for (int m = 0; m < 4; m++) begin
      nine_bit_mode = m[0];
      tx_polarity_invert = m[1];
      @(negedge clk);
      transmitter_on = 1'b1;
      for (int i = 0; i < 3; i++) begin
        put(char_t'($urandom_range(0, 511)));
        if (i == 0) begin
          repeat (144) @(negedge clk);
          check({15'h0000, txd ^ tx_polarity_invert}, 16'h0001);
        end
      end
      drain(4000);
      check({14'h0000, txd, txd_oe}, {14'h0000, ~tx_polarity_invert, 1'b1});
      transmitter_on = 1'b0;
      repeat (40) @(negedge clk);
      check({15'h0000, txd_oe}, 16'h0000);
    end
    // slower prescale doubles the bit time
    nine_bit_mode = 1'b0;
    tx_polarity_invert = 1'b0;
    die_link_prescale = 2'h1;
    bit_clks = 8'h20;
    transmitter_on = 1'b1;
    put(char_t'($urandom_range(0, 255)));
    drain(4000);
    die_link_prescale = 2'h0;
    bit_clks = 8'h10;
    // break length for each format
    for (int m = 0; m < 4; m++) begin
      nine_bit_mode = m[0];
      long_break_select = m[1];
      exp_tx.push_back({1'b1, 15'(10 + m[0] + 3 * m[1])});
      queue_break_ctl = 1'b1;
      @(negedge clk);
      queue_break_ctl = 1'b0;
      drain(3000);
    end
    // control held past the load queues a second break; disabling lets both finish
    nine_bit_mode = 1'b0;
    long_break_select = 1'b0;
    exp_tx.push_back({1'b1, 15'd20});
    queue_break_ctl = 1'b1;
    repeat (20) @(negedge clk);
    queue_break_ctl = 1'b0;
    transmitter_on = 1'b0;
    drain(3000);
    // receive every format and polarity
    for (int m = 0; m < 4; m++) begin
      receiver_on = 1'b0;
      nine_bit_mode = m[0];
      rx_polarity_invert = m[1];
      u_peer.idle(m[1]);
      receiver_on = 1'b1;
      repeat (48) @(negedge clk);
      d = char_t'($urandom_range(0, 511));
      exp_rx.push_back({2'b00, m[0] ? d : {1'b0, d[7:0]}});
      u_peer.send(d, 1'b1, m[1], -1);
      drain(1000);
      clear_rx();
    end
    // one flipped sample in a zero data bit: value kept, noise raised
    exp_rx.push_back({2'b10, 9'h0A5});
    u_peer.send(9'h0A5, 1'b1, 1'b1, 4);
    drain(1000);
    clear_rx();
    // second character while full is lost; a data read alone clears nothing
    exp_rx.push_back({2'b00, 9'h011});
    u_peer.send(9'h011, 1'b1, 1'b1, -1);
    u_peer.send(9'h122, 1'b1, 1'b1, -1);
    drain(1000);
    check({3'h0, rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag, rx_data},
          {3'h0, 4'h9, 9'h011});
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    repeat (2) @(negedge clk);
    check({3'h0, rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag, rx_data},
          {3'h0, 4'h9, 9'h011});
    clear_rx();
    // framing error holds off later characters without overrun
    exp_rx.push_back({2'b01, 9'h03C});
    u_peer.send(9'h03C, 1'b0, 1'b1, -1);
    u_peer.send(9'h155, 1'b1, 1'b1, -1);
    drain(1000);
    check({3'h0, rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag, rx_data},
          {3'h0, 4'hA, 9'h03C});
    // preset edge history restarts on the low stop bit; let those frames die out
    repeat (400) @(negedge clk);
    check({3'h0, rx_buffer_full_flag, noise_flag, framing_error_flag, overrun_flag, rx_data},
          {3'h0, 4'hA, 9'h03C});
    clear_rx();
    exp_rx.push_back({2'b00, 9'h0F0});
    u_peer.send(9'h0F0, 1'b1, 1'b1, -1);
    drain(1000);
    // clock enable low freezes the flags, so a whole clear sequence is lost
    ce = 1'b0;
    status_read = 1'b1;
    @(negedge clk);
    status_read = 1'b0;
    data_read = 1'b1;
    @(negedge clk);
    data_read = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    check({15'h0000, rx_buffer_full_flag}, 16'h0001);
    clear_rx();
    summarize();
  end
endmodule

// *** rx_link_if.sv ***
`timescale 1ns/10ps
interface rx_link_if;
  import serial_core_pkg::*;
  logic tick16;
  logic nine_bit;
  logic rx_invert;
  logic enable;
  logic done;
  char_t data;
  logic noise;
  logic framing;
  logic brk;
  modport core (output tick16, nine_bit, rx_invert, enable,
    input done, data, noise, framing, brk);
  modport rxer (input tick16, nine_bit, rx_invert, enable,
    output done, data, noise, framing, brk);
endinterface

// *** serial_core_defines.svh ***
`ifndef SERIAL_CORE_DEFINES_SVH
`define SERIAL_CORE_DEFINES_SVH
// Behaviour
// - baud clock is die clock over prescale
// - transmit line idles high, inversion off
// - inversion flips every transmitted element
// - enabling transmitter queues one idle preamble
// - frame is ten bits, eleven in nine-bit
// - buffer moves to shifter, then buffer-empty sets
// - nothing waiting after stop sets done flag
// - disabling transmitter lets queued idle, break finish
// - break pulse queues break, held requeues
// - break lasts 10, 11, 13 or 14 bits
// - enable off then on queues idle character
// - receive inversion and receiver enable
// - start zero, data LSB first, stop one
// - stop received, empty buffer: load, set full
// - buffer already full: overrun, drop character
// - full clears on status read then data read
// - sixteen samples per bit, edge after three ones
// - start valid if two of slots 3,5,7 zero
// - bit is majority of slots 8,9,10
// - any disagreeing sample sets noise at transfer
// - every detected edge outside start validation realigns the sample phase
// - framing error, not break: history preset ones
// - framing error set blocks transfers, shifter runs

// oversampling phase: value p is sample slot p+1
`define PHASE_LAST 4'hF
`define PHASE_RT3 4'h2
`define PHASE_RT5 4'h4
`define PHASE_RT7 4'h6
`define PHASE_RT8 4'h7
`define PHASE_RT9 4'h8
`define PHASE_RT10 4'h9
`define PHASE_AFTER_EDGE 4'h1
`define HIST_ONES 3'h7

// frame and break lengths in bit times
`define FRAME_BITS_8 4'hA
`define FRAME_BITS_9 4'hB
`define LONG_BREAK_EXTRA 4'h3

// bit index of the stop bit in a received frame
`define STOP_IDX_8 4'h9
`define STOP_IDX_9 4'hA

// shifter idle pattern, also its reset value, and break pattern
`define SHIFT_IDLE 14'h3FFF
`define SHIFT_BREAK 14'h0000
`endif

// *** serial_core_pkg.sv ***
package serial_core_pkg;
  typedef logic [8:0] char_t;
  typedef enum logic {TX_OFF, TX_ACTIVE} tx_state_e;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} rx_state_e;
endpackage

// *** serial_peer.sv ***
`timescale 1ns/10ps
// far-end serial device: decodes the transmit line and drives the receive line
module serial_peer (
  // clocking
  input wire logic clk,
  // line format
  input wire logic nine,
  input wire logic inv,
  input wire logic [7:0] bit_clks,
  // transmit line as seen at the far end
  input wire logic line,
  // receive line toward the core
  output logic rxd,
  // decoded frames: data, or break flag with length in bit times
  output logic [15:0] got_word,
  output logic [7:0] got_cnt
);
  logic ln;

  assign ln = line ^ inv; // undo transmit inversion

  initial begin
    rxd = 1'b1;
    got_word = 16'h0000;
    got_cnt = 8'h00;
  end

  // mid-bit decoding, lsb first; a zero stop bit means a break, so its low run is timed
  initial begin : decode
    logic prev;
    logic [8:0] d;
    int nb;
    int cnt;
    prev = 1'b1;
    forever begin
      @(posedge clk);
      if (prev === 1'b1 && ln === 1'b0) begin
        nb = nine ? 9 : 8;
        d = 9'h000;
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
          repeat (bit_clks) @(posedge clk);
          d[i] = ln; // lsb first
        end
        repeat (bit_clks) @(posedge clk);
        cnt = bit_clks / 2 + bit_clks * (nb + 1);
        if (ln === 1'b1) begin
          got_word = {7'h00, d};
        end else begin
          while (ln !== 1'b1) begin
            @(posedge clk);
            cnt++;
          end
          got_word = {1'b1, 15'((cnt + bit_clks / 2) / bit_clks)};
        end
        got_cnt = got_cnt + 8'h01;
      end
      prev = ln;
    end
  end

  // return the receive line to its idle level for the given polarity
  task automatic idle(input logic rinv);
    @(negedge clk);
    rxd = ~rinv;
  endtask

  // one frame toward the core; glitch flips the mid sample of that bit index
  task automatic send(input logic [8:0] d, input logic stop_v, input logic rinv,
                      input int glitch);
    logic [10:0] fr;
    int nb;
    nb = nine ? 9 : 8;
    fr = nine ? {stop_v, d, 1'b0} : {1'b0, stop_v, d[7:0], 1'b0};
    for (int b = 0; b <= nb + 1; b++) begin
      for (int c = 0; c < bit_clks; c++) begin
        @(negedge clk);
        rxd = fr[b] ^ (b == glitch && c == bit_clks / 2) ^ rinv;
      end
    end
    @(negedge clk);
    rxd = ~rinv;
    repeat (2 * bit_clks) @(negedge clk);
  endtask
endmodule

// *** serial_rx_sampler.sv ***
`timescale 1ns/10ps
`include "serial_core_defines.svh"
module serial_rx_sampler (
  // clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // serial input pin
  input wire logic rxd_pin,
  // link to the core
  rx_link_if.rxer lk
);
  import serial_core_pkg::*;

  logic rx_meta;
  logic rx_sync;
  rx_state_e state;
  logic [3:0] phase;
  logic [3:0] bit_idx;
  logic [2:0] hist;
  logic [1:0] start_zeros;
  logic v8;
  logic v9;
  logic noise_acc;
  char_t shift;

  // decoding of the current sample
  wire s = rx_sync ^ lk.rx_invert;
  wire edge_seen = (hist == `HIST_ONES) && !s;
  wire [1:0] votes = {1'b0, v8} + {1'b0, v9} + {1'b0, s};
  wire bit_val = votes[1];
  wire bit_noisy = (votes != 2'h0) && (votes != 2'h3);
  wire [1:0] zeros_total = start_zeros + {1'b0, !s};
  wire [3:0] stop_idx = lk.nine_bit ? `STOP_IDX_9 : `STOP_IDX_8;
  wire char_t word = lk.nine_bit ? shift : {1'b0, shift[8:1]};
  wire is_break = !bit_val && (word == 9'h000);

  // pin synchroniser, nothing else reads rx_meta
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else if (ce) begin
      rx_meta <= rxd_pin;
      rx_sync <= rx_meta;
    end
  end

  // frame sampler at sixteen ticks per bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= RX_HUNT;
      phase <= 4'h0;
      bit_idx <= 4'h0;
      hist <= 3'h0;
      start_zeros <= 2'h0;
      v8 <= 1'b0;
      v9 <= 1'b0;
      noise_acc <= 1'b0;
      shift <= 9'h000;
      lk.done <= 1'b0;
      lk.data <= 9'h000;
      lk.noise <= 1'b0;
      lk.framing <= 1'b0;
      lk.brk <= 1'b0;
    end else if (ce) begin
      lk.done <= 1'b0;
      if (!lk.enable) begin
        state <= RX_HUNT;
        hist <= 3'h0;
      end else if (lk.tick16) begin
        hist <= {hist[1:0], s};
        phase <= phase + 4'h1;
        unique case (state)
          RX_HUNT: begin
            if (edge_seen) begin
              state <= RX_START;
              phase <= `PHASE_AFTER_EDGE;
              start_zeros <= 2'h0;
              noise_acc <= 1'b0;
              bit_idx <= 4'h0;
            end
          end
          RX_START: begin
            if (phase == `PHASE_RT3 || phase == `PHASE_RT5) begin
              start_zeros <= zeros_total;
              noise_acc <= noise_acc | s;
            end
            // two zeros of three confirm a real start bit
            if (phase == `PHASE_RT7) begin
              state <= zeros_total[1] ? RX_BITS : RX_HUNT;
              noise_acc <= noise_acc | s;
            end
          end
          RX_BITS: begin
            if (edge_seen) phase <= `PHASE_AFTER_EDGE;
            if (phase == `PHASE_RT8) v8 <= s;
            if (phase == `PHASE_RT9) v9 <= s;
            if (phase == `PHASE_RT10) begin
              if (bit_idx == 4'h0) begin
                // start already validated, stays zero whatever the vote
                noise_acc <= noise_acc | (votes != 2'h0);
              end else if (bit_idx != stop_idx) begin
                shift <= {bit_val, shift[8:1]};
                noise_acc <= noise_acc | bit_noisy;
              end else begin
                lk.done <= 1'b1;
                lk.data <= word;
                lk.noise <= noise_acc | bit_noisy;
                lk.framing <= !bit_val;
                lk.brk <= is_break;
                state <= RX_HUNT;
                if (!bit_val && !is_break) hist <= `HIST_ONES;
              end
            end
            if (phase == `PHASE_LAST) bit_idx <= bit_idx + 4'h1;
          end
          default: state <= RX_HUNT;
        endcase
      end
    end
  end

  property p_start_reject;
    @(posedge clk) disable iff (sys_rst)
    (ce && lk.enable && lk.tick16 && state == RX_START && phase == `PHASE_RT7
      && !zeros_total[1]) |=> state == RX_HUNT;
  endproperty
  a_start_reject: assert property (p_start_reject)
    else $error("start bit accepted with fewer than two zero samples");

  property p_history_preset;
    @(posedge clk) disable iff (sys_rst)
    (lk.done && lk.framing && !lk.brk) |-> hist == `HIST_ONES;
  endproperty
  a_history_preset: assert property (p_history_preset)
    else $error("edge history not preset after framing error");
endmodule
